/* src/cnvr_device.sv */
`timescale 1ns/10ps
`include "cnvr_defines.svh"

module cnvr_device
(
	// Clock and reset
	input  wire logic   CLK,
	input  wire logic   RST_N,
	// Link
	cnvr_if.device      link,
	// Microphone function strap pin
	input  wire logic   DIGITAL_MICROPHONE_FUNCTION_ENABLE,
	// Pin state
	output logic        CD_INPUT_ENABLE,
	output logic        MIC_INPUT_ENABLE,
	output logic        CD_JACK_OVERRIDE,
	output logic        MIC_JACK_OVERRIDE
);

	localparam int NUM_PINS = 2;

	// ----------------------------------------
	// Node decode
	// ----------------------------------------
	function automatic logic is_pin_node(input logic [7:0] node);
		is_pin_node = (node == `CNVR_NODE_CD) || (node == `CNVR_NODE_MIC);
	endfunction

	function automatic logic [0:0] pin_index(input logic [7:0] node);
		pin_index = (node == `CNVR_NODE_MIC) ? 1'b1 : 1'b0;
	endfunction

	function automatic cnvr_pkg::cnvr_word_t cfg_reset(input int idx);
		cfg_reset = (idx == 0) ? `CNVR_CFG_RESET_CD : `CNVR_CFG_RESET_MIC;
	endfunction

	logic ours;
	logic pin_hit;
	logic [0:0] pidx;

	assign ours = (link.cmd_node == `CNVR_NODE_MIXER) || is_pin_node(link.cmd_node);
	assign pin_hit = link.cmd_valid && is_pin_node(link.cmd_node);
	assign pidx = pin_index(link.cmd_node);

	// ----------------------------------------
	// Strap synchroniser
	// ----------------------------------------
	logic digital_microphone_function_meta_reg;
	logic digital_microphone_function_sync_reg;

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			digital_microphone_function_meta_reg <= 1'b0;
			digital_microphone_function_sync_reg <= 1'b0;
		end
		else
		begin
			digital_microphone_function_meta_reg <= DIGITAL_MICROPHONE_FUNCTION_ENABLE;
			digital_microphone_function_sync_reg <= digital_microphone_function_meta_reg;
		end
	end

	// ----------------------------------------
	// Pin control and configuration storage
	// ----------------------------------------
	logic                  input_path_enable_reg [NUM_PINS];
	cnvr_pkg::cnvr_word_t  cfg_reg  [NUM_PINS];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++)
		begin : g_pin
			logic sel;
			logic cfg_wr;
			logic [1:0] lane;

			assign sel = pin_hit && (pidx == 1'(gi));
			assign cfg_wr = sel && (link.cmd_verb >= `CNVR_VERB_SET_CFG0)
				&& (link.cmd_verb <= `CNVR_VERB_SET_CFG3);
			assign lane = link.cmd_verb[1:0];

			always_ff @(posedge CLK)
			begin
				if (!RST_N)
					input_path_enable_reg[gi] <= 1'b0;
				else if (sel && link.cmd_verb == `CNVR_VERB_SET_PIN_CONTROL_WORD)
					input_path_enable_reg[gi] <= link.cmd_payload[`CNVR_INPUT_PATH_ENABLE_BIT];
			end

			always_ff @(posedge CLK)
			begin
				if (!RST_N)
					cfg_reg[gi] <= cfg_reset(gi);
				else if (cfg_wr)
				begin
					case (lane)
						2'h0: cfg_reg[gi][7:0] <= link.cmd_payload;
						2'h1: cfg_reg[gi][15:8] <= link.cmd_payload;
						2'h2: cfg_reg[gi][23:16] <= link.cmd_payload;
						default: cfg_reg[gi][31:24] <= link.cmd_payload;
					endcase
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Response selection
	// ----------------------------------------
	cnvr_pkg::cnvr_word_t mixer_word;
	cnvr_pkg::cnvr_word_t pin_word;
	cnvr_pkg::cnvr_word_t rsp_next;
	cnvr_pkg::cnvr_word_t mic_widget_capability_word;

	assign mic_widget_capability_word = digital_microphone_function_sync_reg ? `CNVR_WIDGET_CAPABILITY_WORD_MIC_ON : `CNVR_WIDGET_CAPABILITY_WORD_MIC_OFF;

	always_comb
	begin
		mixer_word = `CNVR_ACK;
		if (link.cmd_verb == `CNVR_VERB_GET_PARAM)
		begin
			if (link.cmd_payload == `CNVR_PARAM_WIDGET_CAPABILITY_WORD)
				mixer_word = `CNVR_WIDGET_CAPABILITY_WORD_MIXER;
			else if (link.cmd_payload == `CNVR_PARAM_CONNECTION_LIST_LENGTH)
				mixer_word = `CNVR_CONNECTION_LIST_LENGTH_MIXER;
		end
		else if (link.cmd_verb == `CNVR_VERB_GET_CONN
			&& link.cmd_payload == `CNVR_CONN_INDEX0)
			mixer_word = `CNVR_CONNECTION_LIST_ENTRIES_MIXER;
	end

	always_comb
	begin
		pin_word = `CNVR_ACK;
		if (link.cmd_verb == `CNVR_VERB_GET_PARAM)
		begin
			if (link.cmd_payload == `CNVR_PARAM_WIDGET_CAPABILITY_WORD)
				pin_word = (pidx == 1'b1) ? mic_widget_capability_word : `CNVR_WIDGET_CAPABILITY_WORD_CD;
			else if (link.cmd_payload == `CNVR_PARAM_PIN_CAPABILITY_WORD)
				pin_word = `CNVR_PIN_CAPABILITY_WORD_INPUT;
		end
		else if (link.cmd_verb == `CNVR_VERB_GET_PIN_CONTROL_WORD)
			pin_word[`CNVR_INPUT_PATH_ENABLE_BIT] = input_path_enable_reg[pidx];
		else if (link.cmd_verb == `CNVR_VERB_GET_CFG)
			pin_word = cfg_reg[pidx];
	end

	// Sets and unknown verbs answer all zero
	assign rsp_next = (link.cmd_node == `CNVR_NODE_MIXER) ? mixer_word : pin_word;

	// ----------------------------------------
	// Response registers
	// ----------------------------------------
	logic                 rsp_valid_reg;
	cnvr_pkg::cnvr_word_t rsp_data_reg;

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			rsp_valid_reg <= 1'b0;
		else
			rsp_valid_reg <= link.cmd_valid && ours;
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			rsp_data_reg <= `CNVR_ACK;
		else if (link.cmd_valid && ours)
			rsp_data_reg <= rsp_next;
	end

	assign link.rsp_valid = rsp_valid_reg;
	assign link.rsp_data = rsp_data_reg;

	// ----------------------------------------
	// Pin state outputs
	// ----------------------------------------
	assign CD_INPUT_ENABLE = input_path_enable_reg[0];
	assign MIC_INPUT_ENABLE = input_path_enable_reg[1];
	assign CD_JACK_OVERRIDE = cfg_reg[0][`CNVR_JACK_OVR_BIT];
	assign MIC_JACK_OVERRIDE = cfg_reg[1][`CNVR_JACK_OVR_BIT];

endmodule

/* inc/cnvr_defines.svh */
`ifndef CNVR_DEFINES_SVH
`define CNVR_DEFINES_SVH

// ----------------------------------------
// Node identifiers
// ----------------------------------------
`define CNVR_NODE_MIXER       8'h15
`define CNVR_NODE_CD          8'h16
`define CNVR_NODE_MIC         8'h17

// ----------------------------------------
// Verbs and payloads
// ----------------------------------------
`define CNVR_VERB_GET_PARAM   12'hf00
`define CNVR_VERB_GET_CONN    12'hf02
`define CNVR_VERB_GET_PIN_CONTROL_WORD  12'hf07
`define CNVR_VERB_SET_PIN_CONTROL_WORD  12'h707
`define CNVR_VERB_GET_CFG     12'hf1c
`define CNVR_VERB_SET_CFG0    12'h71c
`define CNVR_VERB_SET_CFG3    12'h71f
`define CNVR_PARAM_WIDGET_CAPABILITY_WORD       8'h09
`define CNVR_PARAM_PIN_CAPABILITY_WORD     8'h0c
`define CNVR_PARAM_CONNECTION_LIST_LENGTH    8'h0e
`define CNVR_CONN_INDEX0      8'h00

// ----------------------------------------
// Fixed response words
// ----------------------------------------
`define CNVR_WIDGET_CAPABILITY_WORD_MIXER       32'h0020_0100
`define CNVR_WIDGET_CAPABILITY_WORD_CD          32'h0040_0001
`define CNVR_WIDGET_CAPABILITY_WORD_MIC_ON      32'h0040_0001
`define CNVR_WIDGET_CAPABILITY_WORD_MIC_OFF     32'h00f0_0001
`define CNVR_PIN_CAPABILITY_WORD_INPUT     32'h0000_0020
`define CNVR_CONNECTION_LIST_LENGTH_MIXER    32'h0000_0001
`define CNVR_CONNECTION_LIST_ENTRIES_MIXER    32'h0000_0010
`define CNVR_ACK              32'h0000_0000
`define CNVR_INPUT_PATH_ENABLE_BIT         5
`define CNVR_JACK_OVR_BIT     8
`define CNVR_CFG_RESET_CD     32'h5033_00f0
`define CNVR_CFG_RESET_MIC    32'h50a0_00f0

// ----------------------------------------
// Controller register map
// ----------------------------------------
`define CNVR_REG_CMD          8'h00
`define CNVR_REG_RSP          8'h04
`define CNVR_REG_STAT         8'h08
`define CNVR_CMD_NODE_LSB     20
`define CNVR_CMD_VERB_LSB     8
`define CNVR_STAT_BUSY        0
`define CNVR_STAT_DONE        1
`define CNVR_STAT_NOANS       2
`define CNVR_RSP_TIMEOUT      8'h10

`endif

/* inc/cnvr_pkg.sv */
package cnvr_pkg;

	typedef enum logic [0:0]
	{
		CNVR_IDLE,
		CNVR_WAIT
	} cnvr_ctl_state_t;

	typedef logic [31:0] cnvr_word_t;

endpackage

/* inc/cnvr_if.sv */
`timescale 1ns/10ps

interface cnvr_if;
	logic                cmd_valid;
	logic [7:0]          cmd_node;
	logic [11:0]         cmd_verb;
	logic [7:0]          cmd_payload;
	logic                rsp_valid;
	cnvr_pkg::cnvr_word_t rsp_data;

	modport device
	(
		input  cmd_valid,
		input  cmd_node,
		input  cmd_verb,
		input  cmd_payload,
		output rsp_valid,
		output rsp_data
	);

	modport controller
	(
		output cmd_valid,
		output cmd_node,
		output cmd_verb,
		output cmd_payload,
		input  rsp_valid,
		input  rsp_data
	);
endinterface

/* src/cnvr_controller.sv */
`timescale 1ns/10ps
`include "cnvr_defines.svh"

module cnvr_controller
(
	// Clock and reset
	input  wire logic         CLK,
	input  wire logic         RST_N,
	// Software port
	input  wire logic [7:0]   ADDR,
	input  wire logic [31:0]  WDATA,
	input  wire logic         WR,
	input  wire logic         RD,
	output logic [31:0]       RDATA,
	// Link
	cnvr_if.controller        link
);

	cnvr_pkg::cnvr_ctl_state_t state_reg;
	logic                      take;
	logic                      cmd_valid_reg;
	logic [7:0]                node_reg;
	logic [11:0]               verb_reg;
	logic [7:0]                payload_reg;
	logic [7:0]                timer_reg;
	logic                      done_reg;
	logic                      noans_reg;
	cnvr_pkg::cnvr_word_t      rsp_reg;
	cnvr_pkg::cnvr_word_t      rdata_reg;
	logic                      timeout;

	assign take = WR && (ADDR == `CNVR_REG_CMD) && (state_reg == cnvr_pkg::CNVR_IDLE);
	assign timeout = (timer_reg == `CNVR_RSP_TIMEOUT);

	// ----------------------------------------
	// Command issue
	// ----------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			cmd_valid_reg <= 1'b0;
			node_reg <= 8'h00;
			verb_reg <= 12'h000;
			payload_reg <= 8'h00;
		end
		else
		begin
			cmd_valid_reg <= take;
			if (take)
			begin
				node_reg <= WDATA[`CNVR_CMD_NODE_LSB +: 8];
				verb_reg <= WDATA[`CNVR_CMD_VERB_LSB +: 12];
				payload_reg <= WDATA[7:0];
			end
		end
	end

	// ----------------------------------------
	// Answer wait
	// ----------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			state_reg <= cnvr_pkg::CNVR_IDLE;
			timer_reg <= 8'h00;
			done_reg <= 1'b0;
			noans_reg <= 1'b0;
			rsp_reg <= `CNVR_ACK;
		end
		else
		begin
			case (state_reg)
				cnvr_pkg::CNVR_IDLE:
				begin
					timer_reg <= 8'h00;
					if (take)
					begin
						state_reg <= cnvr_pkg::CNVR_WAIT;
						done_reg <= 1'b0;
						noans_reg <= 1'b0;
					end
				end
				default:
				begin
					timer_reg <= timer_reg + 8'h01;
					if (link.rsp_valid)
					begin
						rsp_reg <= link.rsp_data;
						done_reg <= 1'b1;
						state_reg <= cnvr_pkg::CNVR_IDLE;
					end
					else if (timeout)
					begin
						noans_reg <= 1'b1;
						done_reg <= 1'b1;
						state_reg <= cnvr_pkg::CNVR_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			rdata_reg <= 32'h0000_0000;
		else if (RD)
		begin
			if (ADDR == `CNVR_REG_CMD)
				rdata_reg <= {4'h0, node_reg, verb_reg, payload_reg};
			else if (ADDR == `CNVR_REG_RSP)
				rdata_reg <= rsp_reg;
			else if (ADDR == `CNVR_REG_STAT)
			begin
				rdata_reg <= 32'h0000_0000;
				rdata_reg[`CNVR_STAT_BUSY] <= (state_reg == cnvr_pkg::CNVR_WAIT);
				rdata_reg[`CNVR_STAT_DONE] <= done_reg;
				rdata_reg[`CNVR_STAT_NOANS] <= noans_reg;
			end
			else
				rdata_reg <= 32'h0000_0000;
		end
		else
			rdata_reg <= 32'h0000_0000;
	end

	assign RDATA = rdata_reg;
	assign link.cmd_valid = cmd_valid_reg;
	assign link.cmd_node = node_reg;
	assign link.cmd_verb = verb_reg;
	assign link.cmd_payload = payload_reg;

endmodule

/* dv/cnvr_monitor.sv */
`timescale 1ns/10ps

module cnvr_monitor
(
	// Clock and reset
	input wire logic                 CLK,
	input wire logic                 RST_N,
	// Link
	input wire logic                 cmd_valid,
	input wire logic [7:0]           cmd_node,
	input wire logic [11:0]          cmd_verb,
	input wire logic [7:0]           cmd_payload,
	input wire logic                 rsp_valid,
	input wire cnvr_pkg::cnvr_word_t rsp_data
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	logic ours;
	logic get09;
	logic get0c;

	assign ours  = cmd_valid && cmd_node >= 8'h15 && cmd_node <= 8'h17;
	assign get09 = ours && cmd_verb == 12'hf00 && cmd_payload == 8'h09;
	assign get0c = ours && cmd_verb == 12'hf00 && cmd_payload == 8'h0c;

	AST_ANSWER: assert property (ours |-> ##1 rsp_valid)
		else $error("decoded node not answered");
	AST_SILENT: assert property (cmd_valid && !ours |=> !rsp_valid)
		else $error("foreign node answered");
	AST_PULSE: assert property ($rose(rsp_valid) |=> $fell(rsp_valid))
		else $error("answer longer than one cycle");
	AST_MIX_CAP: assert property (get09 && cmd_node == 8'h15 |=> rsp_data == 32'h0020_0100)
		else $error("mixer capability wrong");
	AST_CAP_ZERO: assert property (get09 |=> rsp_data[10] == 1'b0 && rsp_data[7] == 1'b0
		&& rsp_data[19:16] == 4'h0 && rsp_data[31:24] == 8'h00)
		else $error("capability zero fields set");
	AST_LEN: assert property (ours && cmd_node == 8'h15 && cmd_verb == 12'hf00
		&& cmd_payload == 8'h0e |=> rsp_data == 32'h0000_0001)
		else $error("list length wrong");
	AST_LIST: assert property (ours && cmd_node == 8'h15 && cmd_verb == 12'hf02
		&& cmd_payload == 8'h00 |=> rsp_valid && rsp_data == 32'h0000_0010)
		else $error("list entries wrong");
	AST_CD_CAP: assert property (get09 && cmd_node == 8'h16 |=> rsp_data == 32'h0040_0001)
		else $error("cd capability wrong");
	AST_PIN_CAPABILITY_WORD: assert property (get0c && cmd_node != 8'h15 |=> rsp_data == 32'h0000_0020)
		else $error("pin capability wrong");
	AST_ACK: assert property (ours && cmd_verb[11:8] == 4'h7 |=> rsp_data == 32'h0)
		else $error("set not acknowledged with zero");
	AST_PIN_CONTROL_WORD: assert property (ours && cmd_verb == 12'hf07 |=> rsp_data[31:6] == 26'h0
		&& rsp_data[4:0] == 5'h0)
		else $error("pin control reserved bits set");
	AST_MIC_CAP: assert property (get09 && cmd_node == 8'h17 |=> rsp_data[23:20] inside
		{4'h4, 4'hf} && rsp_data[15:0] == 16'h0001)
		else $error("microphone capability wrong");
endmodule

/* dv/codec_node_verb_responder_bench.sv */
`timescale 1ns/10ps
`include "cnvr_defines.svh"

module codec_node_verb_responder_bench;
	typedef struct packed
	{
		logic [7:0]  node;
		logic [11:0] verb;
		logic [7:0]  pl;
		logic [31:0] exp;
	} cnvr_row_t;

	logic        clk;
	logic        rst_n;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        digital_microphone_function_en;
	logic        cd_in;
	logic        mic_in;
	logic        cd_jack;
	logic        mic_jack;
	logic [31:0] d;
	logic [31:0] st;
	int          n_fail;
	int          num_checks;
	cnvr_row_t   rows [10];
	logic [7:0]  bytes [4];
	logic [31:0] cfg [4];

	cnvr_if link_if();

	cnvr_device cnvr_device_inst
	(
		.CLK               (clk),
		.RST_N             (rst_n),
		.link              (link_if),
		.DIGITAL_MICROPHONE_FUNCTION_ENABLE       (digital_microphone_function_en),
		.CD_INPUT_ENABLE   (cd_in),
		.MIC_INPUT_ENABLE  (mic_in),
		.CD_JACK_OVERRIDE  (cd_jack),
		.MIC_JACK_OVERRIDE (mic_jack)
	);

	cnvr_controller cnvr_controller_inst
	(
		.CLK   (clk),
		.RST_N (rst_n),
		.ADDR  (addr),
		.WDATA (wdata),
		.WR    (wr),
		.RD    (rd),
		.RDATA (rdata),
		.link  (link_if)
	);

	cnvr_monitor cnvr_monitor_inst
	(
		.CLK         (clk),
		.RST_N       (rst_n),
		.cmd_valid   (link_if.cmd_valid),
		.cmd_node    (link_if.cmd_node),
		.cmd_verb    (link_if.cmd_verb),
		.cmd_payload (link_if.cmd_payload),
		.rsp_valid   (link_if.rsp_valid),
		.rsp_data    (link_if.rsp_data)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	// Launch one verb, poll for done, fetch the answer
	task automatic send(input logic [7:0] n, input logic [11:0] v, input logic [7:0] p);
		st = 32'h0;
		wr_reg(`CNVR_REG_CMD, {4'h0, n, v, p});
		for (int i = 0; i < 40 && st[1] !== 1'b1; i++)
			rd_reg(`CNVR_REG_STAT, st);
		chk({31'h0, st[1]}, 32'h1);
		rd_reg(`CNVR_REG_RSP, d);
	endtask

	task automatic do_reset(input int n);
		rst_n <= 1'b0;
		repeat (n) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({28'h0, cd_in, mic_in, cd_jack, mic_jack}, 32'h0);
	endtask

	task automatic complete_run;
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		#20000;
		n_fail++;
		complete_run;
	end

	initial
	begin
		addr       = 8'h00;
		wdata      = 32'h0;
		wr         = 1'b0;
		rd         = 1'b0;
		digital_microphone_function_en    = 1'b1;
		rst_n      = 1'b0;
		n_fail     = 0;
		num_checks = 0;
		rows = '{
			'{8'h15, 12'hf00, 8'h09, 32'h0020_0100},
			'{8'h15, 12'hf00, 8'h0e, 32'h0000_0001},
			'{8'h15, 12'hf02, 8'h00, 32'h0000_0010},
			'{8'h16, 12'hf00, 8'h09, 32'h0040_0001},
			'{8'h16, 12'hf00, 8'h0c, 32'h0000_0020},
			'{8'h17, 12'hf00, 8'h0c, 32'h0000_0020},
			'{8'h17, 12'hf00, 8'h09, 32'h0040_0001},
			'{8'h16, 12'hf07, 8'h00, 32'h0000_0000},
			'{8'h16, 12'hf1c, 8'h00, 32'h5033_00f0},
			'{8'h17, 12'hf1c, 8'h00, 32'h50a0_00f0}};
		bytes = '{8'ha5, 8'h01, 8'h3c, 8'h12};
		cfg   = '{32'h50a0_00a5, 32'h50a0_01a5, 32'h503c_01a5, 32'h123c_01a5};
		do_reset(4);
		foreach (rows[i])
		begin
			send(rows[i].node, rows[i].verb, rows[i].pl);
			chk(d, rows[i].exp);
		end
		send(8'h16, 12'h707, 8'hff);
		chk(d, 32'h0);
		send(8'h16, 12'hf07, 8'h00);
		chk(d, 32'h0000_0020);
		send(8'h17, 12'h707, 8'h20);
		chk({30'h0, cd_in, mic_in}, 32'h3);
		for (int k = 0; k < 4; k++)
		begin
			send(8'h17, 12'h71c + 12'(k), bytes[k]);
			send(8'h17, 12'hf1c, 8'h00);
			chk(d, cfg[k]);
		end
		chk({30'h0, cd_jack, mic_jack}, 32'h1);
		@(posedge clk);
		digital_microphone_function_en <= 1'b0;
		repeat (4) @(posedge clk);
		send(8'h17, 12'hf00, 8'h09);
		chk(d, 32'h00f0_0001);
		send(8'h20, 12'hf00, 8'h09);
		chk(st, 32'h6);
		rd_reg(`CNVR_REG_CMD, d);
		chk(d, {4'h0, 8'h20, 12'hf00, 8'h09});
		rd_reg(8'h40, d);
		chk(d, 32'h0);
		@(posedge clk);
		do_reset(2);
		send(8'h17, 12'hf1c, 8'h00);
		chk(d, 32'h50a0_00f0);
		complete_run;
	end
endmodule
